/* core/pac_delay_line.sv */
// fixed-depth shift register carrying words through the conversion pipeline
`timescale 1ns/10ps
`default_nettype none
module pac_delay_line #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] stage_reg [DEPTH];

  if (DEPTH < 1 || WIDTH < 1) begin : g_check
    $error("pac_delay_line needs DEPTH and WIDTH of at least one");
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_stage
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        stage_reg[i] <= '0;
      end else if (i == 0) begin
        stage_reg[i] <= data_in;
      end else begin
        stage_reg[i] <= stage_reg[(i == 0) ? 0 : i - 1];
      end
    end
  end

  assign data_out = stage_reg[DEPTH-1];
endmodule // pac_delay_line
`default_nettype wire

/* core/pac_output_ctrl.sv */
// pipelined converter output control: pins, latency, coding, tri-state, power modes
`timescale 1ns/10ps
`default_nettype none
module pac_output_ctrl
  import pac_pkg::*;
#(
  parameter int WORD_WIDTH = PAC_WORD_WIDTH,
  parameter int LATENCY = PAC_LATENCY
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // quantizer result for the sample taken at this edge
  input wire logic [WORD_WIDTH-1:0] core_sample_in,
  input wire logic core_over_range_in,
  // level pins from the board
  input wire logic coding_select_in,
  input wire logic output_enable_n_in,
  input wire logic output_enable_driven_in,
  input wire logic dcs_select_in,
  input wire logic standard_powerdown_in,
  input wire logic partial_powerdown_in,
  // register port
  input wire logic [PAC_ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // data pins
  output logic [WORD_WIDTH-1:0] sample_word_out,
  output logic sample_word_oe_n_out,
  output logic over_range_flag_out,
  output logic sample_valid_out,
  output logic duty_cycle_stabilizer_out,
  output logic [1:0] power_state_out,
  output logic irq_out
);
  localparam int PIPE_WIDTH = WORD_WIDTH + 2;

  if (WORD_WIDTH != PAC_WORD_WIDTH || LATENCY < 2) begin : g_check
    $error("pac_output_ctrl supports a 12-bit word and a latency of two or more");
  end

  logic [PAC_PIN_COUNT-1:0] pin_raw;
  logic [PAC_PIN_COUNT-1:0] pin_s1_reg;
  logic [PAC_PIN_COUNT-1:0] pin_s2_reg;
  logic [PAC_PIN_COUNT-1:0] pin_s3_reg;
  logic [PAC_PIN_COUNT-1:0] pin_reg;
  pac_power_type power_reg;
  pac_power_type power_next;
  logic capture;
  logic [PIPE_WIDTH-1:0] pipe_in;
  logic [PIPE_WIDTH-1:0] pipe_out;
  logic pipe_valid;
  logic pipe_over;
  logic [WORD_WIDTH-1:0] pipe_word;
  logic [PAC_EVT_COUNT-1:0] status_reg;
  logic [PAC_EVT_COUNT-1:0] status_next;
  logic [PAC_EVT_COUNT-1:0] mask_reg;
  logic [PAC_EVT_COUNT-1:0] events;
  logic [PAC_EVT_COUNT-1:0] clear_bits;

  // floating enable pin is pulled low by the pad, so it reads as enabled
  assign pin_raw[PAC_PIN_OE_N] = output_enable_driven_in & output_enable_n_in;
  assign pin_raw[PAC_PIN_CODING] = coding_select_in;
  assign pin_raw[PAC_PIN_DCS] = dcs_select_in;
  assign pin_raw[PAC_PIN_STD_PD] = standard_powerdown_in;
  assign pin_raw[PAC_PIN_PART_PD] = partial_powerdown_in;

  // pins are asynchronous to the convert clock; a level is taken once two stages agree
  for (genvar p = 0; p < PAC_PIN_COUNT; p++) begin : g_pin_sync
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        pin_s1_reg[p] <= PAC_PIN_RESET[p];
        pin_s2_reg[p] <= PAC_PIN_RESET[p];
        pin_s3_reg[p] <= PAC_PIN_RESET[p];
        pin_reg[p] <= PAC_PIN_RESET[p];
      end else begin
        pin_s1_reg[p] <= pin_raw[p];
        pin_s2_reg[p] <= pin_s1_reg[p];
        pin_s3_reg[p] <= pin_s2_reg[p];
        if (pin_s2_reg[p] == pin_s3_reg[p]) begin
          pin_reg[p] <= pin_s3_reg[p];
        end
      end
    end
  end

  // standard power-down outranks the partial mode when both pins are high
  always_comb begin
    if (pin_reg[PAC_PIN_STD_PD]) begin
      power_next = PAC_STANDARD;
    end else if (pin_reg[PAC_PIN_PART_PD]) begin
      power_next = PAC_PARTIAL;
    end else begin
      power_next = PAC_RUN;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      power_reg <= PAC_RUN;
    end else begin
      power_reg <= power_next;
    end
  end

  // a sample is taken on every edge while running; power-down marks the slot empty
  assign capture = (power_reg == PAC_RUN);
  assign pipe_in = {capture, core_over_range_in, core_sample_in};

  pac_delay_line #(
    .WIDTH(PIPE_WIDTH),
    .DEPTH(LATENCY - 1)
  ) u_pipe (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .data_in(pipe_in),
    .data_out(pipe_out)
  );

  assign pipe_valid = pipe_out[PIPE_WIDTH-1];
  assign pipe_over = pipe_out[PIPE_WIDTH-2];
  assign pipe_word = pipe_out[WORD_WIDTH-1:0];

  // final stage: coding, power gating; partial mode keeps the last word on the pins
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sample_word_out <= '0;
      over_range_flag_out <= 1'b0;
      sample_valid_out <= 1'b0;
    end else if (power_reg == PAC_STANDARD) begin
      sample_word_out <= '0;
      over_range_flag_out <= 1'b0;
      sample_valid_out <= 1'b0;
    end else if (pipe_valid) begin
      sample_word_out[WORD_WIDTH-2:0] <= pipe_word[WORD_WIDTH-2:0];
      sample_word_out[WORD_WIDTH-1] <= pipe_word[WORD_WIDTH-1] ^ pin_reg[PAC_PIN_CODING];
      over_range_flag_out <= pipe_over;
      sample_valid_out <= 1'b1;
    end else begin
      sample_valid_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sample_word_oe_n_out <= 1'b0;
    end else begin
      sample_word_oe_n_out <= pin_reg[PAC_PIN_OE_N];
    end
  end

  // the stabilizer itself is analog; this level selects it and the duty figures are its own
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      duty_cycle_stabilizer_out <= 1'b0;
      power_state_out <= 2'h0;
    end else begin
      duty_cycle_stabilizer_out <= pin_reg[PAC_PIN_DCS];
      power_state_out <= power_reg;
    end
  end

  // events: over-range word leaving, power-down entered, first word after refill
  assign events[PAC_EVT_OVER] = pipe_valid && pipe_over && (power_reg != PAC_STANDARD);
  assign events[PAC_EVT_PDOWN] = (power_reg == PAC_RUN) && (power_next != PAC_RUN);
  assign events[PAC_EVT_REFILL] = pipe_valid && !sample_valid_out
    && (power_reg != PAC_STANDARD);
  assign clear_bits = (reg_wr_in && reg_addr_in == PAC_ADDR_STATUS)
    ? reg_wdata_in[PAC_EVT_COUNT-1:0] : '0;
  // a new event wins over a clear in the same cycle
  assign status_next = (status_reg & ~clear_bits) | events;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      status_reg <= PAC_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mask_reg <= PAC_MASK_RESET;
    end else if (reg_wr_in && reg_addr_in == PAC_ADDR_MASK) begin
      mask_reg <= reg_wdata_in[PAC_EVT_COUNT-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_reg & mask_reg);
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        PAC_ADDR_STATUS: reg_rdata_out <= {29'h0, status_reg};
        PAC_ADDR_MASK: reg_rdata_out <= {29'h0, mask_reg};
        PAC_ADDR_STATE: reg_rdata_out <= {25'h0, power_reg, pin_reg};
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // helper ages for the stream assertions: edges spent running or powered down in a row;
  // a counter keeps the repetition out of the properties so the latency can grow freely
  localparam int AGE_WIDTH = $clog2(LATENCY + 1);
  localparam logic [AGE_WIDTH-1:0] AGE_FULL = AGE_WIDTH'(LATENCY);
  logic [AGE_WIDTH-1:0] run_age_reg;
  logic [AGE_WIDTH-1:0] idle_age_reg;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || power_reg != PAC_RUN) begin
      run_age_reg <= '0;
    end else if (run_age_reg != AGE_FULL) begin
      run_age_reg <= run_age_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || power_reg == PAC_RUN) begin
      idle_age_reg <= '0;
    end else if (idle_age_reg != AGE_FULL) begin
      idle_age_reg <= idle_age_reg + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  a_latency_data: assert property (
    sample_valid_out && !$past(rst_in, 5) |->
      sample_word_out[WORD_WIDTH-2:0] == $past(core_sample_in[WORD_WIDTH-2:0], LATENCY))
    else $error("word low bits do not match the sample five cycles back");
  a_msb_coding: assert property (
    $rose(sample_valid_out) || (sample_valid_out && $past(sample_valid_out)) |->
      sample_word_out[WORD_WIDTH-1] ==
      ($past(core_sample_in[WORD_WIDTH-1], LATENCY) ^ $past(pin_reg[PAC_PIN_CODING])))
    else $error("msb coding wrong for selected format");
  a_over_range_align: assert property (
    sample_valid_out |-> over_range_flag_out == $past(core_over_range_in, LATENCY))
    else $error("over-range flag not aligned with its word");
  a_oe_follows_pin: assert property (
    $past(pin_s3_reg[PAC_PIN_OE_N], 2) == $past(pin_s2_reg[PAC_PIN_OE_N], 2) |->
      sample_word_oe_n_out == $past(pin_s3_reg[PAC_PIN_OE_N], 2))
    else $error("data enable does not follow the enable pin");
  a_oe_undriven: assert property (
    !output_enable_driven_in [*4] |=> ##1 !sample_word_oe_n_out)
    else $error("undriven enable pin did not keep outputs enabled");
  a_std_pd_quiet: assert property (
    $past(power_reg) == PAC_STANDARD |-> !sample_valid_out && sample_word_out == '0)
    else $error("outputs not quiet in standard power-down");
  a_part_pd_hold: assert property (
    power_reg == PAC_PARTIAL && !pipe_valid |=> $stable(sample_word_out))
    else $error("partial power-down did not hold the output word");
  a_stream_rate: assert property (
    run_age_reg == AGE_FULL |-> sample_valid_out)
    else $error("running converter missed a word");
  a_dcs_select: assert property (
    $past(pin_reg[PAC_PIN_DCS]) |-> duty_cycle_stabilizer_out)
    else $error("stabilizer select not applied");
  a_pd_no_valid: assert property (
    idle_age_reg == AGE_FULL |-> !sample_valid_out)
    else $error("word marked fresh after the pipeline drained in power-down");
  a_status_sticky: assert property (
    (($past(status_reg) & ~$past(clear_bits)) & ~status_reg) == '0)
    else $error("status bit dropped without a clear");
  a_event_wins: assert property (
    ($past(events) & ~status_reg) == '0)
    else $error("event lost against a clear");
  a_read_window: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == '0)
    else $error("read data outside the cycle after a read");

  c_stream: cover property (sample_valid_out [*8]);
  c_over_range: cover property (sample_valid_out && over_range_flag_out);
  c_wake: cover property ((power_reg == PAC_STANDARD) ##1 (power_reg == PAC_RUN) ##[1:8] $rose(sample_valid_out));
  c_irq: cover property ($rose(irq_out));
  c_partial_exit: cover property ((power_reg == PAC_PARTIAL) ##1 (power_reg == PAC_RUN));
endmodule // pac_output_ctrl
`default_nettype wire

/* core/pac_pkg.sv */
// constants and types shared by the converter output control block
package pac_pkg;
  localparam int PAC_WORD_WIDTH = 12;
  localparam int PAC_LATENCY = 5;
  localparam int PAC_SYNC_STAGES = 3;
  localparam int PAC_PIN_COUNT = 5;
  // pin positions inside the synchronised pin vector
  localparam int PAC_PIN_CODING = 0;
  localparam int PAC_PIN_OE_N = 1;
  localparam int PAC_PIN_DCS = 2;
  localparam int PAC_PIN_STD_PD = 3;
  localparam int PAC_PIN_PART_PD = 4;
  // register byte addresses
  localparam int PAC_ADDR_WIDTH = 4;
  localparam logic [3:0] PAC_ADDR_STATUS = 4'h0;
  localparam logic [3:0] PAC_ADDR_MASK = 4'h4;
  localparam logic [3:0] PAC_ADDR_STATE = 4'h8;
  // status and mask bit positions
  localparam int PAC_EVT_COUNT = 3;
  localparam int PAC_EVT_OVER = 0;
  localparam int PAC_EVT_PDOWN = 1;
  localparam int PAC_EVT_REFILL = 2;
  // reset values
  localparam logic [2:0] PAC_STATUS_RESET = 3'h0;
  localparam logic [2:0] PAC_MASK_RESET = 3'h0;
  localparam logic [4:0] PAC_PIN_RESET = 5'h00;
  typedef enum logic [1:0] {
    PAC_RUN,
    PAC_PARTIAL,
    PAC_STANDARD
  } pac_power_type;
endpackage

/* verification/pac_capture_model.sv */
// capture logic at the far side: takes each driven, fresh word from the data pins
`timescale 1ns/10ps
`default_nettype none
module pac_capture_model (
  input wire logic sys_clk_in,
  input wire logic [11:0] word_in,
  input wire logic oe_n_in,
  input wire logic valid_in,
  output logic [11:0] last_word_out,
  output int word_count_out
);
  initial word_count_out = 0;
  initial last_word_out = 12'h000;
  // a floating bus is never latched, so only driven words count
  always @(posedge sys_clk_in) begin
    if (valid_in === 1'b1 && oe_n_in === 1'b0) begin
      last_word_out <= word_in;
      word_count_out <= word_count_out + 1;
    end
  end
endmodule // pac_capture_model
`default_nettype wire

/* verification/pac_output_ctrl_tb_top.sv */
// self-checking bench for the converter output control block
`timescale 1ns/10ps
`default_nettype none
module pac_output_ctrl_tb_top;
  import pac_pkg::*;
  logic clk, rst, over_range_flag, cod, oen, drv, duty_cycle_stabilizer, spd, ppd, wr, rd, gen_ovr;
  logic [11:0] smp, word, cap;
  logic [3:0] addr;
  logic [31:0] wd, rdat, r;
  logic oen_o, flag, valid, dcs_o, irq;
  logic [1:0] pst;
  logic [12:0] hist [0:4];
  int errors, cmp_count, cnt;

  pac_output_ctrl i_pac_output_ctrl (.sys_clk_in(clk), .rst_in(rst), .core_sample_in(smp),
    .core_over_range_in(over_range_flag), .coding_select_in(cod), .output_enable_n_in(oen),
    .output_enable_driven_in(drv), .dcs_select_in(duty_cycle_stabilizer), .standard_powerdown_in(spd),
    .partial_powerdown_in(ppd), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdat), .sample_word_out(word),
    .sample_word_oe_n_out(oen_o), .over_range_flag_out(flag), .sample_valid_out(valid),
    .duty_cycle_stabilizer_out(dcs_o), .power_state_out(pst), .irq_out(irq));
  pac_capture_model i_pac_capture_model (.sys_clk_in(clk), .word_in(word), .oe_n_in(oen_o),
    .valid_in(valid), .last_word_out(cap), .word_count_out(cnt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // odd step walks every code; over-range marks one sample in eight
  always @(posedge clk) begin
    smp <= smp + 12'h0a7;
    over_range_flag <= gen_ovr && (smp[2:0] == 3'h0);
    hist[0] <= {over_range_flag, smp};
    for (int i = 1; i < 5; i++) hist[i] <= hist[i-1];
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdat;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic t_regs;
    reg_read(PAC_ADDR_STATUS, r);
    check("status", r, 32'h0);
    reg_read(PAC_ADDR_MASK, r);
    check("mask", r, 32'h0);
    reg_write(PAC_ADDR_STATE, 32'hffff_ffff);
    reg_read(PAC_ADDR_STATE, r);
    check("state", r, 32'h0);
    reg_read(4'hc, r);
    check("unmapped", r, 32'h0);
  endtask
  // five-edge latency, msb coding and over-range alignment, word by word
  task automatic t_stream(input logic c);
    int c0;
    logic [11:0] prev;
    @(posedge clk);
    cod <= c;
    wait_clk(12);
    @(negedge clk);
    c0 = cnt;
    prev = hist[4][11:0] ^ {c, 11'h0};
    repeat (20) begin
      @(negedge clk);
      check("model word", cap, prev);
      prev = hist[4][11:0] ^ {c, 11'h0};
      check("word", word, prev);
      check("flag", flag, hist[4][12]);
      check("valid", valid, 1'b1);
    end
    check("captured", cnt - c0, 20);
  endtask
  task automatic t_irq;
    reg_read(PAC_ADDR_STATUS, r);
    check("over status", r[PAC_EVT_OVER], 1'b1);
    gen_ovr <= 1'b0;
    reg_write(PAC_ADDR_MASK, 32'h1);
    wait_clk(2);
    check("irq", irq, 1'b1);
    wait_clk(8);
    reg_write(PAC_ADDR_STATUS, 32'h7);
    wait_clk(2);
    check("irq clear", irq, 1'b0);
  endtask
  task automatic t_pins;
    oen <= 1'b1;
    duty_cycle_stabilizer <= 1'b1;
    wait_clk(8);
    check("oe_n", oen_o, 1'b1);
    check("dcs", dcs_o, 1'b1);
    reg_read(PAC_ADDR_STATE, r);
    check("pins", r[4:0], 5'h07);
    drv <= 1'b0;
    duty_cycle_stabilizer <= 1'b0;
    wait_clk(8);
    check("float oe", oen_o, 1'b0);
    check("dcs off", dcs_o, 1'b0);
    drv <= 1'b1;
    oen <= 1'b0;
  endtask
  task automatic t_power(input logic [1:0] m);
    logic [11:0] held;
    reg_write(PAC_ADDR_MASK, 32'h2);
    if (m == 2'h1) ppd <= 1'b1;
    else spd <= 1'b1;
    wait_clk(10);
    held = word;
    wait_clk(3);
    check("pstate", pst, m);
    check("pd valid", valid, 1'b0);
    check("pd word", word, (m == 2'h2) ? 12'h000 : held);
    check("pd irq", irq, 1'b1);
    reg_read(PAC_ADDR_STATE, r);
    check("state mode", r[6:5], m);
    ppd <= 1'b0;
    spd <= 1'b0;
    wait_clk(14);
    check("run", pst, 2'h0);
    check("run valid", valid, 1'b1);
    reg_write(PAC_ADDR_STATUS, 32'h7);
    wait_clk(2);
    check("pd clear", irq, 1'b0);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    end_of_test();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    {rst, over_range_flag, cod, oen, duty_cycle_stabilizer, spd, ppd, wr, rd} = 9'h100;
    drv = 1'b1;
    gen_ovr = 1'b1;
    smp = 12'h000;
    addr = 4'h0;
    wd = 32'h0;
    wait_clk(3);
    rst <= 1'b0;
    t_regs();
    t_stream(1'b0);
    t_stream(1'b1);
    t_irq();
    t_pins();
    t_power(2'h1);
    t_power(2'h2);
    t_stream(1'b0);
    end_of_test();
  end
endmodule // pac_output_ctrl_tb_top
`default_nettype wire
